// ### shared/fsac_pkg.sv
// Behaviour
// [RULE1] A bus fault on a vector table fetch sets the vector-read flag, bit 1.
// [RULE2] A vector table read fault always goes to hard fault, never bus fault.
// [RULE3] With the flag set, stacked return address is the preempted instruction.
// [RULE4] Writing one clears the vector-read flag; writing zero leaves it alone.
// [RULE5] Bit 0 of hard fault status reads zero and ignores writes.
// [RULE6] Software preserves reserved bits on read-modify-write and ignores them.
// [RULE7] A 32-bit fault address register at 0xd34 captures the faulting address.
// [RULE8] An unaligned fault records the actual faulting address, not the requested one.
// [RULE9] A split access may record any byte address inside the access span.
// [RULE10] The fault address is valid only while the address-valid flag is set.
// [RULE11] Only privileged accesses may read or write the fault address register.
// [RULE12] Address and valid flag load in the fault cycle, held until next fault or write.
package fsac_pkg;
  localparam int          ADDR_W            = 12;
  localparam logic [11:0] HFS_OFFSET        = 12'hd2c;
  localparam logic [11:0] MMFS_OFFSET       = 12'hd28;
  localparam logic [11:0] MMFA_OFFSET       = 12'hd34;
  localparam logic [11:0] IRQ_STATUS_OFFSET = 12'hd40;
  localparam logic [11:0] IRQ_MASK_OFFSET   = 12'hd44;
  localparam int          VECTOR_READ_FAULT_FLAG_BIT          = 1;
  localparam int          MM_ADDRESS_VALID_BIT         = 7;
  localparam int          IRQ_VECTOR_READ_FAULT_FLAG_BIT      = 0;
  localparam int          IRQ_MM_BIT        = 1;
  localparam logic [31:0] ZERO_WORD         = 32'h0000_0000;
  localparam logic [1:0]  ZERO_IRQ          = 2'h0;
endpackage

// ### tb/fault_status_address_capture_tb.sv
`timescale 1ns/1ns
module fault_status_address_capture_tb;
  import fsac_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] reg_addr = 12'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic        reg_priv = 1'b1;
  logic        rd_pend = 1'b0;
  logic [31:0] reg_rdata, mm_fault_addr, preempted_pc, stacked_pc, a;
  logic        reg_error, vector_fetch_fault, mm_fault, exc_entry;
  logic        hard_fault_req, bus_fault_req, irq;
  logic [32:0] exp_q[$];
  int          n_fail = 0;
  int          checks_done = 0;
  int          seed = 34;

  // Clock of 40 ns period.
  always #20 sys_clk = ~sys_clk;

  fsac_fault_status dut_u (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_priv, .reg_rdata, .reg_error, .vector_fetch_fault, .mm_fault, .mm_fault_addr,
    .exc_entry, .preempted_pc, .hard_fault_req, .bus_fault_req, .stacked_pc, .irq);
  fsac_core_model core_u (.sys_clk, .vector_fetch_fault, .mm_fault, .mm_fault_addr,
    .exc_entry, .preempted_pc);

  // Compares one result and counts it.
  task automatic chk(input logic [32:0] seen, input logic [32:0] want);
    checks_done++;
    if (seen !== want) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask

  // One-cycle register write.
  task automatic wr(input logic [11:0] ad, input logic [31:0] d, input logic p);
    @(posedge sys_clk);
    reg_write <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
    reg_priv <= p;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask

  // One-cycle register read; the expected {error, data} is queued first.
  task automatic rd(input logic [11:0] ad, input logic p, input logic [32:0] e);
    exp_q.push_back(e);
    @(posedge sys_clk);
    reg_read <= 1'b1;
    reg_addr <= ad;
    reg_priv <= p;
    @(posedge sys_clk);
    reg_read <= 1'b0;
  endtask

  // Watcher: the answer of a read stands in the cycle after it.
  always @(posedge sys_clk) rd_pend <= reg_read;
  always @(negedge sys_clk) begin
    chk({32'h0, bus_fault_req}, 33'h0);
    if (rd_pend) begin
      chk({reg_error, reg_rdata}, exp_q.pop_front());
    end
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run length.
  initial begin
    #100000;
    n_fail++;
    tally_and_finish();
  end

  // Main sequence.
  initial begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    rd(HFS_OFFSET, 1'b1, 33'h0);
    rd(MMFS_OFFSET, 1'b1, 33'h0);
    rd(12'h000, 1'b1, 33'h1_0000_0000);
    wr(IRQ_MASK_OFFSET, 32'h3, 1'b1);
    rd(IRQ_MASK_OFFSET, 1'b1, 33'h3);
    $display("test reset_decode done");
    core_u.vec_fault();
    #1;
    chk({32'h0, hard_fault_req}, 33'h1);
    chk({32'h0, irq}, 33'h1);
    rd(HFS_OFFSET, 1'b1, 33'h2);
    wr(HFS_OFFSET, 32'hffff_fffd, 1'b1);
    rd(HFS_OFFSET, 1'b1, 33'h2);
    wr(HFS_OFFSET, 32'h2, 1'b1);
    rd(HFS_OFFSET, 1'b1, 33'h0);
    rd(IRQ_STATUS_OFFSET, 1'b1, 33'h1);
    #1;
    chk({32'h0, irq}, 33'h0);
    a = $random(seed);
    core_u.exc(a);
    #1;
    chk({1'b0, stacked_pc}, {1'b0, a});
    $display("test vector_fault done");
    a = $random(seed);
    core_u.mm(a);
    #1;
    chk({32'h0, irq}, 33'h1);
    rd(MMFS_OFFSET, 1'b1, 33'h80);
    rd(MMFA_OFFSET, 1'b1, {1'b0, a});
    rd(MMFA_OFFSET, 1'b0, 33'h1_0000_0000);
    wr(MMFA_OFFSET, ~a, 1'b0);
    #1;
    chk({32'h0, reg_error}, 33'h1);
    rd(MMFA_OFFSET, 1'b1, {1'b0, a});
    wr(MMFS_OFFSET, 32'h80, 1'b1);
    rd(MMFS_OFFSET, 1'b1, 33'h0);
    wr(MMFA_OFFSET, ~a, 1'b1);
    rd(MMFA_OFFSET, 1'b1, {1'b0, ~a});
    rd(IRQ_STATUS_OFFSET, 1'b1, 33'h2);
    $display("test mm_capture done");
    for (int i = 0; i < 4; i++) begin
      a = $random(seed);
      fork
        core_u.mm(a);
        wr(MMFS_OFFSET, 32'h80, 1'b1);
      join
      rd(MMFS_OFFSET, 1'b1, 33'h80);
      rd(MMFA_OFFSET, 1'b1, {1'b0, a});
    end
    $display("test fault_vs_clear done");
    wr(IRQ_MASK_OFFSET, 32'h0, 1'b1);
    core_u.vec_fault();
    #1;
    chk({32'h0, irq}, 33'h0);
    rd(IRQ_STATUS_OFFSET, 1'b1, 33'h3);
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rd(HFS_OFFSET, 1'b1, 33'h0);
    rd(MMFS_OFFSET, 1'b1, 33'h0);
    rd(IRQ_MASK_OFFSET, 1'b1, 33'h0);
    repeat (2) @(posedge sys_clk);
    chk(33'(exp_q.size()), 33'h0);
    $display("test mask_and_reset done");
    tally_and_finish();
  end
endmodule

// ### tb/fsac_core_model.sv
`timescale 1ns/1ns
// Core-side fault source; each task raises its event for exactly one cycle.
module fsac_core_model (
  input  wire logic        sys_clk,
  output logic             vector_fetch_fault,
  output logic             mm_fault,
  output logic      [31:0] mm_fault_addr,
  output logic             exc_entry,
  output logic      [31:0] preempted_pc
);
  // Idle levels at time zero.
  initial begin
    vector_fetch_fault = 1'b0;
    mm_fault = 1'b0;
    exc_entry = 1'b0;
    mm_fault_addr = 32'h0;
    preempted_pc = 32'h0;
  end
  // A bus fault on a vector table fetch.
  task automatic vec_fault();
    @(posedge sys_clk) vector_fetch_fault <= 1'b1;
    @(posedge sys_clk) vector_fetch_fault <= 1'b0;
  endtask
  // Address lines show the inverse once released, so stale values never match.
  task automatic mm(input logic [31:0] a);
    @(posedge sys_clk);
    mm_fault <= 1'b1;
    mm_fault_addr <= a;
    @(posedge sys_clk);
    mm_fault <= 1'b0;
    mm_fault_addr <= ~a;
  endtask
  // Exception entry with the address of the preempted instruction.
  task automatic exc(input logic [31:0] pc);
    @(posedge sys_clk);
    exc_entry <= 1'b1;
    preempted_pc <= pc;
    @(posedge sys_clk);
    exc_entry <= 1'b0;
    preempted_pc <= ~pc;
  endtask
endmodule

// ### verilog/fsac_addr_capture.sv
`timescale 1ns/1ns
// Fault address capture with its valid flag.
module fsac_addr_capture #(
  parameter int AW = 32
) (
  input  wire logic          sys_clk,
  input  wire logic          rst,
  input  wire logic          fault,
  input  wire logic [AW-1:0] fault_addr,
  input  wire logic          sw_write,
  input  wire logic [AW-1:0] sw_data,
  input  wire logic          valid_clear,
  output logic      [AW-1:0] addr,
  output logic               valid
);
  // The address is the access that actually faulted, so split accesses land anywhere in span.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      addr <= '0;
    end else if (fault) begin
      addr <= fault_addr; // RULE8 RULE9 RULE12
    end else if (sw_write) begin
      addr <= sw_data; // RULE12
    end
  end

  // Valid flag; a fault wins over a software clear.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      valid <= 1'b0;
    end else if (fault) begin
      valid <= 1'b1; // RULE10 RULE12
    end else if (valid_clear) begin
      valid <= 1'b0;
    end
  end

  property p_capture;
    @(posedge sys_clk) disable iff (rst) fault |=> (valid && addr == $past(fault_addr));
  endproperty
  a_capture: assert property (p_capture) else $error("Fault address not captured."); // RULE12

  property p_hold;
    @(posedge sys_clk) disable iff (rst) (!fault && !sw_write) |=> $stable(addr);
  endproperty
  a_hold: assert property (p_hold) else $error("Fault address changed without cause."); // RULE12
endmodule

// ### verilog/fsac_fault_status.sv
`timescale 1ns/1ns
module fsac_fault_status (
  input  wire logic                        sys_clk,
  input  wire logic                        rst,
  input  wire logic [fsac_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]                 reg_wdata,
  input  wire logic                        reg_write,
  input  wire logic                        reg_read,
  input  wire logic                        reg_priv,
  output logic      [31:0]                 reg_rdata,
  output logic                             reg_error,
  input  wire logic                        vector_fetch_fault,
  input  wire logic                        mm_fault,
  input  wire logic [31:0]                 mm_fault_addr,
  input  wire logic                        exc_entry,
  input  wire logic [31:0]                 preempted_pc,
  output logic                             hard_fault_req,
  output logic                             bus_fault_req,
  output logic      [31:0]                 stacked_pc,
  output logic                             irq
);
  import fsac_pkg::*;

  logic        vector_read_fault_flag;
  logic        mm_address_valid;
  logic [31:0] memmanage_fault_address;
  logic [1:0]  irq_status;
  logic [1:0]  irq_mask;
  logic [1:0]  next_irq_status;

  // Address decode.
  wire hit_hfs   = (reg_addr == HFS_OFFSET);
  wire hit_mmfs  = (reg_addr == MMFS_OFFSET);
  wire hit_mmfa  = (reg_addr == MMFA_OFFSET); // RULE7
  wire hit_ists  = (reg_addr == IRQ_STATUS_OFFSET);
  wire hit_imask = (reg_addr == IRQ_MASK_OFFSET);
  wire mapped    = hit_hfs | hit_mmfs | hit_mmfa | hit_ists | hit_imask;
  // Fault address register refuses unprivileged accesses.
  wire mmfa_ok   = hit_mmfa & reg_priv; // RULE11
  wire denied    = (reg_write | reg_read) & ((hit_mmfa & !reg_priv) | !mapped);

  // Write strobes; only bit 1 of hard fault status is writable, bit 0 is ignored.
  wire vector_read_fault_flag_clear  = reg_write & hit_hfs & reg_wdata[VECTOR_READ_FAULT_FLAG_BIT]; // RULE4 RULE5
  wire mmfa_write  = reg_write & mmfa_ok; // RULE11
  wire mm_address_valid_clear = reg_write & hit_mmfs & reg_wdata[MM_ADDRESS_VALID_BIT];
  wire ists_read   = reg_read & hit_ists;

  // Read data; reserved bits including bit 0 read as zero.
  wire [31:0] hfs_word   = {31'h0, vector_read_fault_flag} << VECTOR_READ_FAULT_FLAG_BIT; // RULE1 RULE5
  wire [31:0] mmfs_word  = {31'h0, mm_address_valid} << MM_ADDRESS_VALID_BIT; // RULE10
  wire [31:0] mmfa_word  = mmfa_ok ? memmanage_fault_address : ZERO_WORD; // RULE11
  wire [31:0] irq_word   = {30'h0, irq_status};
  wire [31:0] mask_word  = {30'h0, irq_mask};
  wire [31:0] read_mux   = hit_hfs   ? hfs_word  :
                           hit_mmfs  ? mmfs_word :
                           hit_mmfa  ? mmfa_word :
                           hit_ists  ? irq_word  :
                           hit_imask ? mask_word : ZERO_WORD;

  fsac_vector_read_fault_flag_flag u_vector_read_fault_flag (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .set_pulse   (vector_fetch_fault),
    .clear_pulse (vector_read_fault_flag_clear),
    .flag        (vector_read_fault_flag)
  );

  fsac_addr_capture #(.AW(32)) u_cap (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .fault       (mm_fault),
    .fault_addr  (mm_fault_addr),
    .sw_write    (mmfa_write),
    .sw_data     (reg_wdata),
    .valid_clear (mm_address_valid_clear),
    .addr        (memmanage_fault_address),
    .valid       (mm_address_valid)
  );

  // Read data register, valid only in the cycle after a read strobe.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= ZERO_WORD;
      reg_error <= 1'b0;
    end else begin
      reg_rdata <= reg_read ? read_mux : ZERO_WORD;
      reg_error <= denied;
    end
  end

  // Vector fetch faults escalate to hard fault and never raise a bus fault.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hard_fault_req <= 1'b0;
      bus_fault_req  <= 1'b0;
    end else begin
      hard_fault_req <= vector_fetch_fault; // RULE2
      bus_fault_req  <= 1'b0; // RULE2
    end
  end

  // Stacked return address is the preempted instruction's address.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stacked_pc <= ZERO_WORD;
    end else if (exc_entry) begin
      stacked_pc <= preempted_pc; // RULE3
    end
  end

  // Sticky interrupt status; events win over the clear-on-read.
  always_comb begin
    next_irq_status = ists_read ? ZERO_IRQ : irq_status;
    next_irq_status[IRQ_VECTOR_READ_FAULT_FLAG_BIT] = next_irq_status[IRQ_VECTOR_READ_FAULT_FLAG_BIT] | vector_fetch_fault;
    next_irq_status[IRQ_MM_BIT]   = next_irq_status[IRQ_MM_BIT] | mm_fault;
  end

  // Status, mask and interrupt line.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_status <= ZERO_IRQ;
      irq_mask   <= ZERO_IRQ;
      irq        <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      if (reg_write && hit_imask) begin
        irq_mask <= reg_wdata[1:0];
      end
      irq        <= |(next_irq_status & irq_mask);
    end
  end

  // A vector table fault escalates to hard fault and never to bus fault.
  property p_vector_read_fault_flag_hard;
    @(posedge sys_clk) disable iff (rst) vector_fetch_fault |=> hard_fault_req && !bus_fault_req;
  endproperty
  a_vector_read_fault_flag_hard: assert property (p_vector_read_fault_flag_hard) // RULE2
    else $error("Vector fault not routed to hard fault.");

  // Hard fault is requested only by a vector table fault.
  property p_hard_only;
    @(posedge sys_clk) disable iff (rst) !vector_fetch_fault |=> !hard_fault_req;
  endproperty
  a_hard_only: assert property (p_hard_only) // RULE2
    else $error("Hard fault raised without vector fault.");

  // Exception entry stacks the address of the preempted instruction.
  property p_pc;
    @(posedge sys_clk) disable iff (rst) exc_entry |=> stacked_pc == $past(preempted_pc);
  endproperty
  a_pc: assert property (p_pc) // RULE3
    else $error("Stacked address wrong.");

  // The stacked address holds between exception entries.
  property p_pc_hold;
    @(posedge sys_clk) disable iff (rst) !exc_entry |=> $stable(stacked_pc);
  endproperty
  a_pc_hold: assert property (p_pc_hold) // RULE3
    else $error("Stacked address changed without entry.");

  // Reserved bit 0 always reads as zero.
  property p_bit0;
    @(posedge sys_clk) disable iff (rst) (reg_read && hit_hfs) |=> reg_rdata[0] == 1'b0;
  endproperty
  a_bit0: assert property (p_bit0) // RULE5
    else $error("Reserved bit read nonzero.");

  // The reserved bits above the flag read as zero as well.
  property p_hfs_upper;
    @(posedge sys_clk) disable iff (rst)
      (reg_read && hit_hfs) |=> (reg_rdata >> (VECTOR_READ_FAULT_FLAG_BIT + 1)) == ZERO_WORD;
  endproperty
  a_hfs_upper: assert property (p_hfs_upper) // RULE5
    else $error("Reserved upper bits read nonzero.");

  // A read of hard fault status reports the flag as it stood at the strobe.
  property p_vector_read_fault_flag_read;
    @(posedge sys_clk) disable iff (rst)
      (reg_read && hit_hfs) |=> reg_rdata[VECTOR_READ_FAULT_FLAG_BIT] == $past(vector_read_fault_flag);
  endproperty
  a_vector_read_fault_flag_read: assert property (p_vector_read_fault_flag_read) // RULE1
    else $error("Vector flag read wrong.");

  // The flag rises only on a vector table fault.
  property p_vector_read_fault_flag_rise;
    @(posedge sys_clk) disable iff (rst)
      (!vector_read_fault_flag && !vector_fetch_fault) |=> !vector_read_fault_flag;
  endproperty
  a_vector_read_fault_flag_rise: assert property (p_vector_read_fault_flag_rise) // RULE1
    else $error("Vector flag set without fault.");

  // Writing zero to the flag's bit leaves it set.
  property p_zero_write;
    @(posedge sys_clk) disable iff (rst)
      (vector_read_fault_flag && reg_write && hit_hfs && !reg_wdata[VECTOR_READ_FAULT_FLAG_BIT]) |=>
      vector_read_fault_flag;
  endproperty
  a_zero_write: assert property (p_zero_write) // RULE4
    else $error("Zero write cleared flag.");

  // Writing one to the flag's bit clears it unless a fault comes in the same cycle.
  property p_one_write;
    @(posedge sys_clk) disable iff (rst)
      (vector_read_fault_flag_clear && !vector_fetch_fault) |=> !vector_read_fault_flag;
  endproperty
  a_one_write: assert property (p_one_write) // RULE4
    else $error("One write did not clear flag.");

  // An unprivileged read of the fault address returns zero and an error.
  property p_unpriv;
    @(posedge sys_clk) disable iff (rst)
      (reg_read && hit_mmfa && !reg_priv) |=> reg_rdata == ZERO_WORD && reg_error;
  endproperty
  a_unpriv: assert property (p_unpriv) // RULE11
    else $error("Unprivileged access accepted.");

  // An unprivileged write leaves the fault address alone and reports an error.
  property p_unpriv_write;
    @(posedge sys_clk) disable iff (rst)
      (reg_write && hit_mmfa && !reg_priv && !mm_fault) |=>
      $stable(memmanage_fault_address) && reg_error;
  endproperty
  a_unpriv_write: assert property (p_unpriv_write) // RULE11
    else $error("Unprivileged write accepted.");

  // A privileged access to the fault address register raises no error.
  property p_priv_ok;
    @(posedge sys_clk) disable iff (rst) ((reg_read || reg_write) && mmfa_ok) |=> !reg_error;
  endproperty
  a_priv_ok: assert property (p_priv_ok) // RULE11
    else $error("Privileged access refused.");

  // The data lines stay at zero outside an answer, so no stale address leaks.
  property p_rdata_idle;
    @(posedge sys_clk) disable iff (rst) !reg_read |=> reg_rdata == ZERO_WORD;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) // RULE11
    else $error("Read data shown without a read.");

  // An error is reported only for a strobe.
  property p_error_idle;
    @(posedge sys_clk) disable iff (rst) !(reg_read || reg_write) |=> !reg_error;
  endproperty
  a_error_idle: assert property (p_error_idle) // RULE11
    else $error("Error raised without an access.");

  // A privileged read returns the captured fault address.
  property p_addr_read;
    @(posedge sys_clk) disable iff (rst)
      (reg_read && mmfa_ok) |=> reg_rdata == $past(memmanage_fault_address);
  endproperty
  a_addr_read: assert property (p_addr_read) // RULE7
    else $error("Fault address read wrong.");

  // A privileged write loads the fault address when no fault competes.
  property p_addr_write;
    @(posedge sys_clk) disable iff (rst)
      (mmfa_write && !mm_fault) |=> memmanage_fault_address == $past(reg_wdata);
  endproperty
  a_addr_write: assert property (p_addr_write) // RULE7
    else $error("Fault address write lost.");

  // A fault sets the address-valid flag in the next cycle.
  property p_valid;
    @(posedge sys_clk) disable iff (rst) mm_fault |=> mm_address_valid;
  endproperty
  a_valid: assert property (p_valid) // RULE10
    else $error("Valid flag not set.");

  // The valid flag rises only on a fault.
  property p_valid_rise;
    @(posedge sys_clk) disable iff (rst) (!mm_address_valid && !mm_fault) |=> !mm_address_valid;
  endproperty
  a_valid_rise: assert property (p_valid_rise) // RULE10
    else $error("Valid flag set without fault.");

  // Writing one to the valid bit clears it unless a fault comes in the same cycle.
  property p_valid_clear;
    @(posedge sys_clk) disable iff (rst) (mm_address_valid_clear && !mm_fault) |=> !mm_address_valid;
  endproperty
  a_valid_clear: assert property (p_valid_clear) // RULE10
    else $error("Valid flag not cleared.");

  // A read of fault status reports the valid flag as it stood at the strobe.
  property p_valid_read;
    @(posedge sys_clk) disable iff (rst)
      (reg_read && hit_mmfs) |=> reg_rdata[MM_ADDRESS_VALID_BIT] == $past(mm_address_valid);
  endproperty
  a_valid_read: assert property (p_valid_read) // RULE10
    else $error("Valid flag read wrong.");

  // A vector table fault lands in the sticky interrupt status.
  property p_irq_vector_read_fault_flag;
    @(posedge sys_clk) disable iff (rst) vector_fetch_fault |=> irq_status[IRQ_VECTOR_READ_FAULT_FLAG_BIT];
  endproperty
  a_irq_vector_read_fault_flag: assert property (p_irq_vector_read_fault_flag) // RULE1
    else $error("Vector fault missing from interrupt status.");

  // An address fault lands in the sticky interrupt status.
  property p_irq_mm;
    @(posedge sys_clk) disable iff (rst) mm_fault |=> irq_status[IRQ_MM_BIT];
  endproperty
  a_irq_mm: assert property (p_irq_mm) // RULE12
    else $error("Address fault missing from interrupt status.");

  // Main scenarios worth seeing in a run.
  c_vector_read_fault_flag: cover property (@(posedge sys_clk) vector_fetch_fault ##[1:5] vector_read_fault_flag_clear);
  c_mm: cover property (@(posedge sys_clk) mm_fault ##[1:5] (reg_read && mmfa_ok));
  c_irq: cover property (@(posedge sys_clk) irq ##[1:5] ists_read);
  c_unpriv: cover property (@(posedge sys_clk) reg_read && hit_mmfa && !reg_priv);
  c_race: cover property (@(posedge sys_clk) mm_fault && mm_address_valid_clear);
endmodule

// ### verilog/fsac_vector_read_fault_flag_flag.sv
`timescale 1ns/1ns
// Sticky vector-read fault flag with write-one-to-clear; a set wins over a clear.
module fsac_vector_read_fault_flag_flag (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic set_pulse,
  input  wire logic clear_pulse,
  output logic      flag
);
  // Flag update.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flag <= 1'b0;
    end else if (set_pulse) begin
      flag <= 1'b1; // RULE1
    end else if (clear_pulse) begin
      flag <= 1'b0; // RULE4
    end
  end

  property p_set_wins;
    @(posedge sys_clk) disable iff (rst) set_pulse |=> flag;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("Vector flag not set by fault."); // RULE1

  property p_clear_only;
    @(posedge sys_clk) disable iff (rst) (flag && !clear_pulse) |=> flag;
  endproperty
  a_clear_only: assert property (p_clear_only) // RULE4
    else $error("Vector flag dropped without clear.");
endmodule
